/* File: hdl/tmb_pkg.sv */
// Shared constants and types for the event timer block
package tmb_pkg;

   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] TMB_OFF_CONTROL_A     = 8'h00;
   localparam logic [7:0] TMB_OFF_CONTROL_B     = 8'h04;
   localparam logic [7:0] TMB_OFF_EVENT_CONTROL = 8'h08;
   localparam logic [7:0] TMB_OFF_INT_FLAGS     = 8'h0C;
   localparam logic [7:0] TMB_OFF_STATUS        = 8'h10;
   localparam logic [7:0] TMB_OFF_COUNT         = 8'h14;
   localparam logic [7:0] TMB_OFF_COMPARE       = 8'h18;

   // Field positions
   localparam int TMB_CA_ENABLE_BIT   = 0;
   localparam int TMB_CA_CLOCK_SOURCE_SELECT_LSB   = 1;
   localparam int TMB_CB_MODE_LSB     = 0;
   localparam int TMB_CB_OUT_EN_BIT   = 4;
   localparam int TMB_EC_EDGE_BIT     = 0;
   localparam int TMB_EC_USER_BIT     = 1;
   localparam int TMB_IF_CAPTURE_INTERRUPT_BIT     = 0;
   localparam int TMB_IF_OVF_BIT      = 1;
   localparam int TMB_ST_RUN_BIT      = 0;

   // Counter limits
   localparam logic [15:0] TMB_BOTTOM      = 16'h0000;
   localparam logic [15:0] TMB_MAX         = 16'hFFFF;
   localparam logic [15:0] TMB_COMPARE_RST = 16'h0000;

   // Counter modes, eight in all
   typedef enum logic [2:0] {
      TMB_MODE_PERIODIC = 3'b000,
      TMB_MODE_TIMEOUT  = 3'b001,
      TMB_MODE_CAPTURE_INTERRUPT_EVT = 3'b010,
      TMB_MODE_FREQ     = 3'b011,
      TMB_MODE_PULSE_W  = 3'b100,
      TMB_MODE_FREQ_PW  = 3'b101,
      TMB_MODE_SINGLE   = 3'b110,
      TMB_MODE_PWM8     = 3'b111
   } tmb_mode_t;

   // Counting clock sources
   typedef enum logic [2:0] {
      TMB_CLK_DIV1      = 3'b000,
      TMB_CLK_DIV2      = 3'b001,
      TMB_CLK_DIV4      = 3'b010,
      TMB_CLK_COMPANION = 3'b011,
      TMB_CLK_EVENT     = 3'b100
   } tmb_clock_source_select_t;

   // Ticks and event edges handed to the counter
   typedef struct packed {
      logic tick;
      logic ev_rise;
      logic ev_fall;
   } tmb_tick_t;

endpackage : tmb_pkg

/* File: hdl/tmb_tick_gen.sv */
// Counting tick and event edge generator
`timescale 1ns/1ns
`default_nettype none
module tmb_tick_gen
   import tmb_pkg::*;
(
   input  wire logic        clk_i,             // Peripheral clock
   input  wire logic        rst_i,             // Sync reset, high
   input  wire logic        enable_i,          // Counter enabled
   input  wire tmb_clock_source_select_t clock_source_select_i,          // Tick source
   input  wire logic        companion_tick_i,  // Companion timer tick
   input  wire logic        event_clk_i,       // Event channel used as clock
   input  wire logic        event_i,           // Event control input
   output var tmb_tick_t    ticks_o            // Registered ticks and edges
);

   typedef struct packed {
      logic [2:0] presc;
      logic       clk_prev;
      logic       ev_prev;
      tmb_tick_t  out;
   } tmb_tick_state_t;

   tmb_tick_state_t st;
   tmb_tick_state_t next_st;
   logic            src_tick;

   // Source select and edge detection
   always_comb begin
      next_st  = st;
      src_tick = 1'b0;
      next_st.presc = enable_i ? st.presc + 3'h1 : 3'h0;
      case (clock_source_select_i)                                       // R21
         TMB_CLK_DIV1:      src_tick = 1'b1;                // R01
         TMB_CLK_DIV2:      src_tick = (st.presc[0] == 1'b0);
         TMB_CLK_DIV4:      src_tick = (st.presc[1:0] == 2'h0);
         TMB_CLK_COMPANION: src_tick = companion_tick_i;    // R02
         TMB_CLK_EVENT:     src_tick = event_clk_i & ~st.clk_prev;
         default:           src_tick = 1'b0;
      endcase
      // Edges assume pulses wider than one clock
      next_st.out.tick    = enable_i & src_tick;
      next_st.out.ev_rise = event_i & ~st.ev_prev;          // R11
      next_st.out.ev_fall = ~event_i & st.ev_prev;
      next_st.clk_prev    = event_clk_i;
      next_st.ev_prev     = event_i;
   end

   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign ticks_o = st.out;

   companion_lockstep_a: assert property (@(posedge clk_i) disable iff (rst_i) // R02
      (enable_i && clock_source_select_i == TMB_CLK_COMPANION) |=> (ticks_o.tick == $past(companion_tick_i)))
      else $error("companion tick not followed");

endmodule : tmb_tick_gen
`default_nettype wire

/* File: hdl/tmb_event_timer.sv */
// Event timer: periodic interrupt and time-out check counter with Wishbone registers
// Function
// R01: Counting clock comes from prescaled clock, companion timer, or event channel.
// R02: With companion clock selected, count advances with each companion timer tick.
// R03: Software selects an event channel as clock for event-controlled operation.
// R04: One base counter serves eight modes chosen by a three-bit field; here every mode but time-out runs the periodic engine.
// R05: Reset leaves the block in periodic interrupt mode.
// R06: Counter spans 0x0000 to 0xFFFF; top is compare value.
// R07: Output enable puts the waveform on the pin instead of port data.
// R08: Enable bit starts counting on ticks of the selected source.
// R09: Count is readable; reaching top raises capture flag and event.
// R10: Compare lowered below count makes the counter run to maximum and wrap.
// R11: Event pulses must last longer than one clock to be seen.
// R12: Periodic mode counts up to compare value then restarts at zero.
// R13: Periodic mode past top raises overflow flag and event at maximum.
// R14: Time-out mode starts on first edge, stops on next, then holds.
// R15: While frozen, a new start edge restarts counting from zero.
// R16: Edge polarity bit picks which edge starts and which stops.
// R17: Time-out mode reaching top before stop raises capture flag and event.
// R18: Time-out mode past top raises overflow at maximum and restarts.
// R19: Frozen reads of count or compare, or status writes, change nothing.
// R20: Time-out mode reacts to edges only when configured as event user.
// R21: Clock select codes and prescaler ratios are local choices.
`timescale 1ns/1ns
`default_nettype none
module tmb_event_timer
   import tmb_pkg::*;
#(
   parameter int ADR_W = 8                       // Wishbone address width
) (
   input  wire logic             clk_i,           // Peripheral clock, 125 MHz
   input  wire logic             rst_i,           // Sync reset, high
   input  wire logic             wb_cyc_i,        // Bus cycle
   input  wire logic             wb_stb_i,        // Strobe
   input  wire logic             wb_we_i,         // Write enable
   input  wire logic [ADR_W-1:0] wb_adr_i,        // Byte address
   input  wire logic [3:0]       wb_sel_i,        // Byte lanes
   input  wire logic [31:0]      wb_dat_i,        // Write data
   output logic      [31:0]      wb_dat_o,        // Read data
   output logic                  wb_ack_o,        // Acknowledge
   input  wire logic             companion_tick_i, // Companion timer tick
   input  wire logic             event_clk_i,     // Event channel as clock
   input  wire logic             event_i,         // Event control input
   input  wire logic             port_out_i,      // Port output value for the pin
   output logic                  waveform_out_o,  // Pin value
   output logic                  capture_interrupt_o,  // Sticky capture flag
   output logic                  overflow_interrupt_o, // Sticky overflow flag
   output logic                  capture_event_o, // Capture event pulse
   output logic                  overflow_event_o // Overflow event pulse
);

   typedef struct packed {
      logic        enable;
      tmb_clock_source_select_t clock_source_select;
      tmb_mode_t   mode;
      logic        out_en;
      logic        edge_pol;
      logic        ev_user;
      logic [15:0] cnt;
      logic [15:0] compare_capture_value;
      logic        run;
      logic        flag_capture_interrupt;
      logic        flag_ovf;
      logic        capture_interrupt_evt;
      logic        ovf_evt;
      logic        wave_pin;
      logic        ack;
      logic [31:0] rdata;
   } tmb_state_t;

   tmb_state_t st;
   tmb_state_t next_st;
   tmb_tick_t  tk;
   logic       start_edge;
   logic       stop_edge;
   logic       bus_req;
   logic       wave;
   logic [7:0] adr;

   // Tick source and event edges
   tmb_tick_gen u_tick (
      .clk_i            (clk_i),
      .rst_i            (rst_i),
      .enable_i         (st.enable),
      .clock_source_select_i         (st.clock_source_select),
      .companion_tick_i (companion_tick_i),
      .event_clk_i      (event_clk_i),
      .event_i          (event_i),
      .ticks_o          (tk)
   );

   // Counter, flags, pin and register access
   always_comb begin
      next_st          = st;
      next_st.capture_interrupt_evt = 1'b0;
      next_st.ovf_evt  = 1'b0;
      next_st.ack      = 1'b0;
      adr              = wb_adr_i[7:0];
      bus_req          = wb_cyc_i & wb_stb_i & ~st.ack;
      // Edges only count once the block listens to the router
      start_edge = st.ev_user & (st.edge_pol ? tk.ev_fall : tk.ev_rise); // R16 R20
      stop_edge  = st.ev_user & (st.edge_pol ? tk.ev_rise : tk.ev_fall); // R16

      // Counting engine
      if (!st.enable) begin
         next_st.run = 1'b0;
      end else if (st.mode == TMB_MODE_TIMEOUT) begin             // R03
         if (!st.run) begin
            if (start_edge) begin                                 // R15
               next_st.cnt = TMB_BOTTOM;
               next_st.run = 1'b1;                                // R14
            end
         end else if (stop_edge) begin
            next_st.run = 1'b0;                                   // R14
         end else if (tk.tick) begin
            if (st.cnt == st.compare_capture_value) begin
               next_st.capture_interrupt_evt = 1'b1;                           // R17
            end
            if (st.cnt == TMB_MAX) begin
               next_st.ovf_evt = 1'b1;                            // R18
               next_st.cnt     = TMB_BOTTOM;
            end else begin
               next_st.cnt = st.cnt + 16'h0001;
            end
         end
      end else begin
         // Other modes share the periodic engine
         next_st.run = 1'b1;                                      // R08
         if (tk.tick) begin
            if (st.cnt == st.compare_capture_value) begin
               next_st.capture_interrupt_evt = 1'b1;                           // R09
               next_st.cnt      = TMB_BOTTOM;                     // R12
            end else if (st.cnt == TMB_MAX) begin
               next_st.ovf_evt = 1'b1;                            // R13
               next_st.cnt     = TMB_BOTTOM;                      // R10
            end else begin
               next_st.cnt = st.cnt + 16'h0001;                   // R06
            end
         end
      end

      // Register access; software write beats the count
      if (bus_req) begin
         next_st.ack   = 1'b1;
         next_st.rdata = 32'h0000_0000;
         if (adr == TMB_OFF_CONTROL_A) begin
            next_st.rdata[TMB_CA_ENABLE_BIT] = st.enable;
            next_st.rdata[TMB_CA_CLOCK_SOURCE_SELECT_LSB +: 3] = st.clock_source_select;
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.enable = wb_dat_i[TMB_CA_ENABLE_BIT];      // R08
               next_st.clock_source_select = tmb_clock_source_select_t'(wb_dat_i[TMB_CA_CLOCK_SOURCE_SELECT_LSB +: 3]); // R01
            end
         end else if (adr == TMB_OFF_CONTROL_B) begin
            next_st.rdata[TMB_CB_MODE_LSB +: 3] = st.mode;
            next_st.rdata[TMB_CB_OUT_EN_BIT]    = st.out_en;
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.mode   = tmb_mode_t'(wb_dat_i[TMB_CB_MODE_LSB +: 3]); // R04
               next_st.out_en = wb_dat_i[TMB_CB_OUT_EN_BIT];
            end
         end else if (adr == TMB_OFF_EVENT_CONTROL) begin
            next_st.rdata[TMB_EC_EDGE_BIT] = st.edge_pol;
            next_st.rdata[TMB_EC_USER_BIT] = st.ev_user;
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.edge_pol = wb_dat_i[TMB_EC_EDGE_BIT];
               next_st.ev_user  = wb_dat_i[TMB_EC_USER_BIT];
            end
         end else if (adr == TMB_OFF_INT_FLAGS) begin
            next_st.rdata[TMB_IF_CAPTURE_INTERRUPT_BIT] = st.flag_capture_interrupt;
            next_st.rdata[TMB_IF_OVF_BIT]  = st.flag_ovf;
            // Write one to clear; a set in the same cycle wins below
            if (wb_we_i && wb_sel_i[0]) begin
               if (wb_dat_i[TMB_IF_CAPTURE_INTERRUPT_BIT]) begin
                  next_st.flag_capture_interrupt = 1'b0;
               end
               if (wb_dat_i[TMB_IF_OVF_BIT]) begin
                  next_st.flag_ovf = 1'b0;
               end
            end
         end else if (adr == TMB_OFF_STATUS) begin
            // Read only: writes to run are dropped in every state
            next_st.rdata[TMB_ST_RUN_BIT] = st.run;               // R19
         end else if (adr == TMB_OFF_COUNT) begin
            next_st.rdata[15:0] = st.cnt;                         // R09 R19
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.cnt[7:0] = wb_dat_i[7:0];
            end
            if (wb_we_i && wb_sel_i[1]) begin
               next_st.cnt[15:8] = wb_dat_i[15:8];
            end
         end else if (adr == TMB_OFF_COMPARE) begin
            // Plain read: no flag is cleared in these modes
            next_st.rdata[15:0] = st.compare_capture_value;                        // R19
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.compare_capture_value[7:0] = wb_dat_i[7:0];
            end
            if (wb_we_i && wb_sel_i[1]) begin
               next_st.compare_capture_value[15:8] = wb_dat_i[15:8];
            end
         end else begin
            // Unmapped: acknowledged, reads zero
            next_st.rdata = 32'h0000_0000;
         end
      end

      // Sticky flags, set beats clear
      if (next_st.capture_interrupt_evt) begin
         next_st.flag_capture_interrupt = 1'b1;                                // R09 R17
      end
      if (next_st.ovf_evt) begin
         next_st.flag_ovf = 1'b1;                                 // R13 R18
      end

      // Waveform high while counting below compare
      wave = st.run & (st.cnt < st.compare_capture_value);
      next_st.wave_pin = st.out_en ? wave : port_out_i;           // R07
   end

   // State register; all-zero reset selects periodic mode
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st <= '0;                                                // R05
         st.compare_capture_value <= TMB_COMPARE_RST;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from state flops
   assign wb_dat_o             = st.rdata;
   assign wb_ack_o             = st.ack;
   assign waveform_out_o       = st.wave_pin;
   assign capture_interrupt_o  = st.flag_capture_interrupt;
   assign overflow_interrupt_o = st.flag_ovf;
   assign capture_event_o      = st.capture_interrupt_evt;
   assign overflow_event_o     = st.ovf_evt;

   // Checks on the design's own behaviour
   ack_single_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   capture_at_top_a: assert property (@(posedge clk_i) disable iff (rst_i) // R09
      capture_event_o |-> $past(tk.tick && st.enable && st.cnt == st.compare_capture_value))
      else $error("capture event without count at top");

   periodic_restart_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
      (st.enable && st.mode == TMB_MODE_PERIODIC && tk.tick && st.cnt == st.compare_capture_value && !bus_req)
      |=> (st.cnt == TMB_BOTTOM && capture_event_o))
      else $error("periodic count did not restart at top");

   overflow_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
      (st.enable && st.mode == TMB_MODE_PERIODIC && tk.tick && st.cnt == TMB_MAX
       && st.compare_capture_value != TMB_MAX && !bus_req)
      |=> (overflow_event_o && st.cnt == TMB_BOTTOM && overflow_interrupt_o))
      else $error("no overflow at maximum");

   freeze_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
      (st.mode == TMB_MODE_TIMEOUT && !st.run && !start_edge && !bus_req)
      |=> $stable(st.cnt))
      else $error("frozen count moved");

   start_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
      (st.enable && st.mode == TMB_MODE_TIMEOUT && !st.run && start_edge && !bus_req)
      |=> (st.run && st.cnt == TMB_BOTTOM))
      else $error("start edge did not restart the count");

   stop_edge_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
      (st.enable && st.mode == TMB_MODE_TIMEOUT && st.run && stop_edge)
      |=> (!st.run ##1 $stable(st.cnt) || start_edge))
      else $error("stop edge did not freeze the count");

   flag_sticky_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
      capture_event_o |-> capture_interrupt_o)
      else $error("capture event left flag clear");

   pin_select_a: assert property (@(posedge clk_i) disable iff (rst_i) // R07
      !$past(st.out_en) |-> (waveform_out_o == $past(port_out_i)))
      else $error("pin not following port value");

endmodule : tmb_event_timer
`default_nettype wire

/* File: tb/tmb_router_model.sv */
// Model of the event router and companion timer feeding the timer's source inputs
`timescale 1ns/1ns
`default_nettype none
module tmb_router_model (
   input  wire logic clk_i,            // Peripheral clock
   input  wire logic rst_i,            // Sync reset, high
   input  wire logic ev_req_i,         // Level the bench asks for
   output logic      companion_tick_o, // Companion tick, one cycle in four
   output logic      event_clk_o,      // Event channel clock, period four
   output logic      event_o           // Event control channel
);
   logic [1:0] phase;
   logic [1:0] hold;

   // One phase counter drives both clocks, so they keep a fixed ratio
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase            <= 2'h0;
         hold             <= 2'h0;
         companion_tick_o <= 1'h0;
         event_clk_o      <= 1'h0;
         event_o          <= 1'h0;
      end else begin
         phase            <= phase + 2'h1;
         companion_tick_o <= (phase == 2'h3);
         event_clk_o      <= phase[1];
         // Each level stands three cycles, so no edge is too short to see
         if (hold != 2'h0) begin
            hold <= hold - 2'h1;
         end else if (ev_req_i != event_o) begin
            event_o <= ev_req_i;
            hold    <= 2'h2;
         end
      end
   end
endmodule : tmb_router_model
`default_nettype wire

/* File: tb/tmb_event_timer_test.sv */
// Self-checking bench for the event timer: registers, clock sources and modes
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tmb_event_timer_test;
   import tmb_pkg::*;
   logic        clk_i = 1'h0;
   logic        rst_i = 1'h1;
   logic        wb_cyc = 1'h0;
   logic        wb_stb = 1'h0;
   logic        wb_we = 1'h0;
   logic [7:0]  wb_adr = 8'h00;
   logic [3:0]  wb_sel = 4'h0;
   logic [31:0] wb_wdat = 32'h0;
   logic [31:0] wb_rdat;
   logic        wb_ack;
   logic        ev_req = 1'h0;
   logic        port_out = 1'h0;
   logic        comp_tick, ev_clk, ev_sig, pin, capture_interrupt_irq, ovf_irq, capture_interrupt_ev, ovf_ev;
   logic        prev;
   logic [31:0] rd;
   logic [15:0] c1;
   int          err_count = 0;
   int          checks_done = 0;
   int          cmp;
   int          n;

   // Free-running clock, 8 ns period
   always #4 clk_i = ~clk_i;

   tmb_event_timer i_tmb_event_timer (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
      .wb_ack_o(wb_ack), .companion_tick_i(comp_tick), .event_clk_i(ev_clk), .event_i(ev_sig),
      .port_out_i(port_out), .waveform_out_o(pin), .capture_interrupt_o(capture_interrupt_irq),
      .overflow_interrupt_o(ovf_irq), .capture_event_o(capture_interrupt_ev), .overflow_event_o(ovf_ev));

   tmb_router_model i_tmb_router_model (.clk_i(clk_i), .rst_i(rst_i), .ev_req_i(ev_req),
      .companion_tick_o(comp_tick), .event_clk_o(ev_clk), .event_o(ev_sig));

   task automatic report_and_stop;
      $display("Checks %0d, mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : report_and_stop

   // One classic cycle; held until ack is sampled, released at that edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_i);
      {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_wdat} <= {2'h3, w, a, 4'hF, d};
      do begin
         @(posedge clk_i);
         k++;
      end while (wb_ack !== 1'h1 && k < 20);
      rd = wb_rdat;
      {wb_cyc, wb_stb, wb_we} <= 3'h0;
      if (wb_ack !== 1'h1) begin
         err_count++;
         $display("Error wb_ack expected 1 seen %0h", wb_ack);
         report_and_stop();
      end
   endtask : wb

   // Bounded wait for a capture (sel 0) or overflow (sel 1) pulse; c returns the cycles spent
   task automatic wait_hi(input logic sel, input int lim, output int c);
      logic s;
      c = 0;
      do begin
         @(posedge clk_i);
         c++;
         s = sel ? ovf_ev : capture_interrupt_ev;
      end while (s !== 1'h1 && c < lim);
      if (s !== 1'h1) begin
         err_count++;
         $display("Error wait expected 1 seen %0h", s);
         report_and_stop();
      end
   endtask : wait_hi

   // Clock cycles per tick for each clock select code
   function automatic int div_of(input int s);
      return (s == 0) ? 1 : (s == 1) ? 2 : 4;
   endfunction : div_of

   initial begin
      n = $urandom(32'hDCEFC4AA);
      repeat (20) @(posedge clk_i);
      rst_i <= 1'h0;
      // Reset values, unmapped place, mode field
      for (int a = 0; a <= 28; a += 4) begin
         wb(1'h0, 8'(a), 32'h0);
         `CHK("reset_reg", 32'h0, rd)
      end
      wb(1'h1, 8'h1C, $urandom);
      wb(1'h0, 8'h1C, 32'h0);
      `CHK("unmapped", 32'h0, rd)
      for (int m = 0; m < 8; m++) begin
         wb(1'h1, TMB_OFF_CONTROL_B, m);
         wb(1'h0, TMB_OFF_CONTROL_B, 32'h0);
         `CHK("mode", m, rd[2:0])
      end
      wb(1'h1, TMB_OFF_CONTROL_B, 32'h0);
      $display("Test registers done");
      // Every clock source: one capture each compare+1 ticks
      for (int s = 0; s < 5; s++) begin
         cmp = 2 + $urandom_range(0, 6);
         wb(1'h1, TMB_OFF_CONTROL_A, 32'h0);
         wb(1'h1, TMB_OFF_COUNT, 32'h0);
         wb(1'h1, TMB_OFF_COMPARE, cmp);
         wb(1'h1, TMB_OFF_CONTROL_A, 1 | (s << 1));
         wait_hi(1'h0, 300, n);
         wait_hi(1'h0, 300, n);
         `CHK("period", (cmp + 1) * div_of(s), n)
         `CHK("capture_interrupt_flag", 1'h1, capture_interrupt_irq)
      end
      wb(1'h1, TMB_OFF_CONTROL_A, 32'h0);
      wb(1'h1, TMB_OFF_INT_FLAGS, 32'h3);
      wb(1'h0, TMB_OFF_INT_FLAGS, 32'h0);
      `CHK("flags_clr", 32'h0, rd)
      $display("Test periodic done");
      // Compare below count: run to maximum, overflow, wrap
      wb(1'h1, TMB_OFF_COUNT, 32'h0000FFF0);
      wb(1'h1, TMB_OFF_COMPARE, 32'h5);
      wb(1'h1, TMB_OFF_CONTROL_A, 32'h1);
      wait_hi(1'h1, 40, n);
      `CHK("no_capture_interrupt", 1'h0, capture_interrupt_irq)
      `CHK("ovf_flag", 1'h1, ovf_irq)
      wait_hi(1'h0, 20, n);
      `CHK("wrap_period", 6, n)
      $display("Test overflow done");
      // Pin follows port data, then the waveform overrides it
      for (int i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (i > 0) `CHK("pin_port", prev, pin)
         prev = port_out;
         port_out <= 1'($urandom);
      end
      port_out <= 1'h0;
      wb(1'h1, TMB_OFF_COMPARE, 32'h3);
      // Count may already sit above the new top; restart it so the period is 4
      wb(1'h1, TMB_OFF_COUNT, 32'h0);
      wb(1'h1, TMB_OFF_CONTROL_B, 32'h10);
      n = 0;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk_i);
         n += int'(pin === 1'h1);
      end
      `CHK("pin_high", 12, n)
      $display("Test waveform done");
      // Time-out check for both edge polarities, event clock selected
      for (int p = 0; p < 2; p++) begin
         wb(1'h1, TMB_OFF_CONTROL_A, 32'h0);
         ev_req <= p[0];
         wb(1'h1, TMB_OFF_CONTROL_B, 32'h1);
         wb(1'h1, TMB_OFF_EVENT_CONTROL, p);
         wb(1'h1, TMB_OFF_COMPARE, 32'h0000FFFF);
         wb(1'h1, TMB_OFF_CONTROL_A, 32'h9);
         ev_req <= ~p[0];
         repeat (8) @(posedge clk_i);
         wb(1'h0, TMB_OFF_STATUS, 32'h0);
         `CHK("not_user", 1'h0, rd[0])
         ev_req <= p[0];
         wb(1'h1, TMB_OFF_EVENT_CONTROL, p | 2);
         ev_req <= ~p[0];
         repeat (40) @(posedge clk_i);
         wb(1'h0, TMB_OFF_STATUS, 32'h0);
         `CHK("started", 1'h1, rd[0])
         ev_req <= p[0];
         repeat (8) @(posedge clk_i);
         wb(1'h0, TMB_OFF_COUNT, 32'h0);
         c1 = rd[15:0];
         wb(1'h0, TMB_OFF_COMPARE, 32'h0);
         wb(1'h1, TMB_OFF_STATUS, 32'h1);
         wb(1'h0, TMB_OFF_STATUS, 32'h0);
         `CHK("stopped", 1'h0, rd[0])
         wb(1'h0, TMB_OFF_COUNT, 32'h0);
         `CHK("frozen", c1, rd[15:0])
         `CHK("counted", 1'h1, c1 > 16'h4)
         ev_req <= ~p[0];
         repeat (8) @(posedge clk_i);
         wb(1'h0, TMB_OFF_COUNT, 32'h0);
         `CHK("restart", 1'h1, rd[15:0] < c1)
      end
      // Running time-out: compare below count, overflow, then capture
      wb(1'h1, TMB_OFF_COMPARE, 32'h2);
      wb(1'h1, TMB_OFF_INT_FLAGS, 32'h3);
      wb(1'h1, TMB_OFF_COUNT, 32'h0000FFF8);
      wait_hi(1'h1, 80, n);
      `CHK("to_ovf", 1'h1, ovf_irq)
      wait_hi(1'h0, 40, n);
      `CHK("to_capture_interrupt", 1'h1, capture_interrupt_irq)
      $display("Test time-out done");
      report_and_stop();
   end
endmodule : tmb_event_timer_test
`default_nettype wire
